// file: rtl/imtf_fifo.sv
// imtf_fifo: small synchronous fifo with valid/ready on both sides
// assumes both sides run on clk; flush empties it in one cycle
`timescale 1ns/1ps

module imtf_fifo
  import imtf_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,      // system clock
  input  wire logic             rst_n,    // synchronous reset, active low
  input  wire logic             flush,    // drop all words
  input  wire logic [WIDTH-1:0] inData,   // word to store
  input  wire logic             inValid,  // inData offered
  output logic                  inReady,  // room for a word
  output logic [WIDTH-1:0]      outData,  // oldest word
  output logic                  outValid, // a word is stored
  input  wire logic             outReady  // consumer takes outData
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];          // storage
  logic [AW-1:0]    wrPtr, next_wrPtr;    // write index
  logic [AW-1:0]    rdPtr, next_rdPtr;    // read index
  logic [AW:0]      count, next_count;    // words held
  logic             push, pop;            // accepted transfers

  ////////////////////////////////////////////////////////////////////////////
  // honest full and empty straight from the count
  assign inReady  = (count != (AW + 1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // pointer and count next values
  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end else begin
      if (push) next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (pop)  next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // register pointers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push && !flush) mem[wrPtr] <= inData;
  end

endmodule : imtf_fifo

// file: rtl/imtf_master.sv
// imtf_master: i2c master byte sequencer with stop, repeated start and read start
// assumes open-drain pads outside; scl and sda pins arrive asynchronously
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - slave pulls sda low: set ack status
// - missed acknowledge: set nack flag, clear ack
// - after nack and stop: drive stop, clear both
// - shift byte; transmit irq after first bit of a write
// - last byte always finishes despite posted request
// - pending request at answer suppresses nack flag
// - issue stop or restart, then clear request
// - nack request makes received byte get nack
module imtf_master
  import imtf_pkg::*;
(
  input  wire logic        clk,      // system clock, 125 MHz
  input  wire logic        rst_n,    // synchronous reset, active low
  input  wire imtf_ctrl_t  ctrl,     // software control bits
  output imtf_stat_t       stat,     // software status bits
  output logic             txIrq,    // transmit interrupt, level
  input  wire logic [7:0]  txData,   // byte for the data path
  input  wire logic        txValid,  // txData offered
  output logic             txReady,  // buffer has room
  output logic [7:0]       rxData,   // received byte
  output logic             rxValid,  // rxData new, one cycle
  input  wire logic        sclIn,    // scl pad level
  output logic             sclOut,   // scl drive value
  output logic             sclOe,    // scl driven low while high
  input  wire logic        sdaIn,    // sda pad level
  output logic             sdaOut,   // sda drive value
  output logic             sdaOe     // sda driven low while high
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage only feeds the second
  logic sclMeta, sclSync, sdaMeta, sdaSync;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter-period enable divider
  logic [DIV_W-1:0] divCnt, next_divCnt;  // counts down to a tick
  logic             tick;                 // one-cycle quarter enable
  assign tick = (divCnt == '0);
  always_comb begin
    next_divCnt = tick ? DIV_RELOAD : divCnt - 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) divCnt <= DIV_RELOAD;
    else        divCnt <= next_divCnt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer
  logic [7:0] fifoData;   // oldest buffered byte
  logic       fifoValid;  // a byte is waiting
  logic       fifoPop;    // byte taken into the shifter
  imtf_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (ctrl.flush),
    .inData   (txData),
    .inValid  (txValid),
    .inReady  (txReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  imtf_state_t state, next_state;               // controller state
  logic [1:0]  q, next_q;                       // quarter of the bit cell
  logic [2:0]  bitCnt, next_bitCnt;             // bit being moved
  logic [7:0]  shiftReg, next_shiftReg;         // byte on the wire
  logic        sclLevel, next_sclLevel;         // scl released when high
  logic        sdaLevel, next_sdaLevel;         // sda released when high
  logic        ackStatus, next_ackStatus;       // acknowledge seen
  logic        nackFlag, next_nackFlag;         // not-acknowledge flag
  logic        startPend, next_startPend;       // start request held
  logic        stopPend, next_stopPend;         // stop request held
  logic        irqPend, next_irqPend;           // transmit interrupt source
  logic        isRead, next_isRead;             // direction of this transaction
  logic        isAddr, next_isAddr;             // shifting the address byte
  logic        needAddr, next_needAddr;         // start done, address not loaded
  logic        nakSend, next_nakSend;           // answer this byte with nack
  logic [7:0]  next_rxData;                     // received byte next
  logic        next_rxValid;                    // receive strobe next
  logic        step;                            // quarter advance
  logic        curBit;                          // bit now due on sda
  logic        sampleAck;                       // acknowledge sample point

  assign curBit    = shiftReg[bitCnt];
  // hold the rise quarter while a slave stretches scl low
  assign step      = tick && !(q == Q_RISE && !sclSync);
  assign sampleAck = (state == IMTF_TACK) && step && (q == Q_HIGH);

  // next values of the whole sequencer
  always_comb begin
    next_state    = state;
    next_q        = step ? q + 1'b1 : q;
    next_bitCnt   = bitCnt;
    next_shiftReg = shiftReg;
    next_sclLevel = sclLevel;
    next_sdaLevel = sdaLevel;
    next_ackStatus = ackStatus;
    next_nackFlag = nackFlag;
    next_startPend = startPend;
    next_stopPend = stopPend;
    next_irqPend  = irqPend && !txValid;  // a new byte answers the interrupt
    next_isRead   = isRead;
    next_isAddr   = isAddr;
    next_needAddr = needAddr;
    next_nakSend  = nakSend;
    next_rxData   = rxData;
    next_rxValid  = 1'b0;
    fifoPop       = 1'b0;
    // scl rises after setup and falls after the high quarter in bit cells
    if (step && (state == IMTF_TX || state == IMTF_TACK || state == IMTF_RX || state == IMTF_RACK ||
                 state == IMTF_START || state == IMTF_STOP)) begin
      if (q == Q_SETUP) next_sclLevel = 1'b1;
      if (q == Q_HIGH && state != IMTF_STOP && state != IMTF_START) next_sclLevel = 1'b0;
    end
    case (state)
      IMTF_IDLE: begin
        next_q = Q_SETUP;
        if (step && startPend) begin    // bus free, launch the start
          next_state    = IMTF_START;
          next_sdaLevel = 1'b1;
        end
      end
      IMTF_START: begin
        if (step && q == Q_HIGH) next_sdaLevel = 1'b0;
        if (step && q == Q_FALL) begin
          next_sclLevel  = 1'b0;
          next_startPend = 1'b0;
          next_needAddr  = 1'b1;
          next_state     = IMTF_HOLD;
        end
      end
      IMTF_TX: begin
        // the byte runs to its end whatever is posted meanwhile
        if (step && q == Q_FALL) begin
          if (bitCnt == MSB_IDX[2:0] && !isRead) next_irqPend = 1'b1;
          if (bitCnt == BIT_LAST) begin
            next_state    = IMTF_TACK;
            next_sdaLevel = 1'b1;
          end else begin
            next_bitCnt   = bitCnt - 1'b1;
            next_sdaLevel = shiftReg[bitCnt - 1'b1];
          end
        end
      end
      IMTF_TACK: begin
        if (sampleAck) begin
          next_ackStatus = !sdaSync;
          if (sdaSync && !stopPend && !startPend) next_nackFlag = 1'b1;
        end
        if (step && q == Q_FALL) begin
          next_isAddr = 1'b0;
          if (stopPend || startPend) begin
            next_state = IMTF_HOLD;
          end else if (ackStatus && isRead && isAddr) begin
            next_state  = IMTF_RX;
            next_bitCnt = BIT_FIRST;
          end else begin
            next_state = IMTF_HOLD;
          end
        end
      end
      IMTF_RX: begin
        if (step && q == Q_HIGH) next_shiftReg[bitCnt] = sdaSync;
        if (step && q == Q_FALL) begin
          if (bitCnt == BIT_LAST) begin
            next_state    = IMTF_RACK;
            next_nakSend  = ctrl.nackRequest;
            next_sdaLevel = ctrl.nackRequest;
            next_rxData   = shiftReg;
            next_rxValid  = 1'b1;
          end else begin
            next_bitCnt = bitCnt - 1'b1;
          end
        end
      end
      IMTF_RACK: begin
        if (step && q == Q_FALL) begin
          next_sdaLevel = 1'b1;
          next_bitCnt   = BIT_FIRST;
          next_state    = (nakSend || stopPend || startPend) ? IMTF_HOLD : IMTF_RX;
        end
      end
      IMTF_STOP: begin
        if (step && q == Q_HIGH) next_sdaLevel = 1'b1;
        if (step && q == Q_FALL) begin
          next_stopPend = 1'b0;
          next_nackFlag = 1'b0;
          next_isRead   = 1'b0;
          next_state    = IMTF_IDLE;
        end
      end
      IMTF_HOLD: begin
        // scl held low until software supplies a byte or a request
        next_q = Q_SETUP;
        if (step) begin
          if (needAddr && fifoValid) begin
            fifoPop       = 1'b1;
            next_needAddr = 1'b0;
            next_shiftReg = fifoData;
            next_isRead   = fifoData[DIR_BIT];
            next_isAddr   = 1'b1;
            next_bitCnt   = BIT_FIRST;
            next_sdaLevel = fifoData[MSB_IDX];
            next_state    = IMTF_TX;
          end else if (!needAddr && stopPend) begin
            next_sdaLevel = 1'b0;
            next_state    = IMTF_STOP;
          end else if (!needAddr && startPend) begin
            next_sdaLevel = 1'b1;
            next_state    = IMTF_START;
          end else if (!needAddr && !nackFlag && !isRead && fifoValid) begin
            fifoPop       = 1'b1;
            next_shiftReg = fifoData;
            next_bitCnt   = BIT_FIRST;
            next_sdaLevel = fifoData[MSB_IDX];
            next_state    = IMTF_TX;
          end
        end
      end
      default: begin
        next_state = IMTF_IDLE;
      end
    endcase
    // software requests: a new request wins over the clear
    if (ctrl.startSet) next_startPend = 1'b1;
    if (ctrl.stopSet)  next_stopPend  = 1'b1;
    // the first-bit set in the transmit branch already wins over a new byte's clear
  end

  // register the sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= IMTF_IDLE;
      q         <= Q_SETUP;
      bitCnt    <= BIT_FIRST;
      shiftReg  <= BYTE_RST;
      sclLevel  <= 1'b1;
      sdaLevel  <= 1'b1;
      ackStatus <= 1'b0;
      nackFlag  <= 1'b0;
      startPend <= 1'b0;
      stopPend  <= 1'b0;
      irqPend   <= 1'b0;
      isRead    <= 1'b0;
      isAddr    <= 1'b0;
      needAddr  <= 1'b0;
      nakSend   <= 1'b0;
      rxData    <= BYTE_RST;
      rxValid   <= 1'b0;
    end else begin
      state     <= next_state;
      q         <= next_q;
      bitCnt    <= next_bitCnt;
      shiftReg  <= next_shiftReg;
      sclLevel  <= next_sclLevel;
      sdaLevel  <= next_sdaLevel;
      ackStatus <= next_ackStatus;
      nackFlag  <= next_nackFlag;
      startPend <= next_startPend;
      stopPend  <= next_stopPend;
      irqPend   <= next_irqPend;
      isRead    <= next_isRead;
      isAddr    <= next_isAddr;
      needAddr  <= next_needAddr;
      nakSend   <= next_nakSend;
      rxData    <= next_rxData;
      rxValid   <= next_rxValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: open-drain pads only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = !sclLevel;
  assign sdaOe  = !sdaLevel;
  assign txIrq  = irqPend && ctrl.txIrqEn;  // gated by software enable
  assign stat   = '{busy: state != IMTF_IDLE, startPending: startPend, stopPending: stopPend,
                    ackStatus: ackStatus, nackFlag: nackFlag};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence stopCond;
    sclLevel && sdaLevel && $past(!sdaLevel);
  endsequence
  sequence startCond;
    sclLevel && !sdaLevel && $past(sdaLevel);
  endsequence

  ack_set_a: assert property (sampleAck && !sdaSync |=> ackStatus)
    else $error("acknowledge not recorded");
  nack_set_a: assert property (sampleAck && sdaSync && !stopPend && !startPend |=> nackFlag && !ackStatus)
    else $error("missed acknowledge not flagged");
  stop_clear_a: assert property (state == IMTF_STOP && step && q == Q_FALL && !ctrl.stopSet
                                 |=> !stopPend && !nackFlag && state == IMTF_IDLE)
    else $error("stop did not clear request and flag");
  irq_first_a: assert property (state == IMTF_TX && step && q == Q_FALL && bitCnt == BIT_FIRST && !isRead
                                |=> irqPend)
    else $error("transmit interrupt missing after first bit");
  byte_finish_a: assert property (state == IMTF_TX && stopPend |=> state == IMTF_TX || state == IMTF_TACK)
    else $error("byte cut short by request");
  nack_masked_a: assert property (sampleAck && (stopPend || startPend) |=> nackFlag == $past(nackFlag))
    else $error("nack flag raised with request pending");
  stop_edge_a: assert property (state == IMTF_STOP && step && q == Q_HIGH |=> stopCond)
    else $error("stop condition not driven");
  start_edge_a: assert property (state == IMTF_START && step && q == Q_HIGH |=> startCond)
    else $error("start condition not driven");
  nak_answer_a: assert property (state == IMTF_RX && step && q == Q_FALL && bitCnt == BIT_LAST && ctrl.nackRequest
                                 |=> state == IMTF_RACK && sdaLevel ##1 sdaLevel)
    else $error("requested nack not sent");
  msb_first_a: assert property (state == IMTF_TX && step && q == Q_FALL && bitCnt != BIT_LAST
                                |=> sdaLevel == $past(shiftReg[bitCnt - 1'b1]))
    else $error("bit order wrong on sda");
  tx_bit_a: assert property (state == IMTF_TX |-> sdaLevel == curBit)
    else $error("sda differs from the current bit");

endmodule : imtf_master

// file: rtl/imtf_pkg.sv
// imtf_pkg: constants and carrier types for the i2c master transaction flow
// assumes a 125 MHz system clock; the quarter cycle count is derived from it here
package imtf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and bus timing
  localparam int unsigned CLK_PERIOD_NS = 8;                 // system clock period
  localparam int unsigned SCL_QTR_NS    = 32;                // least quarter of an scl period
  localparam int unsigned QTR_CYC       = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 3;                 // divider counter width
  localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(QTR_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // byte layout and reset values
  localparam int unsigned BYTE_W      = 8;                   // data width on the wire
  localparam int unsigned DIR_BIT     = 0;                   // direction bit of the address byte
  localparam int unsigned MSB_IDX     = 7;                   // first bit shifted out
  localparam int unsigned FIFO_DEPTH  = 4;                   // transmit buffer words
  localparam logic [2:0]  BIT_FIRST   = 3'h7;                // bit counter at byte start
  localparam logic [2:0]  BIT_LAST    = 3'h0;                // bit counter at byte end
  localparam logic [7:0]  BYTE_RST    = 8'h00;               // data registers after reset

  ////////////////////////////////////////////////////////////////////////////
  // quarter phases of one scl bit cell
  localparam logic [1:0] Q_SETUP = 2'h0;                     // scl low, sda settles
  localparam logic [1:0] Q_RISE  = 2'h1;                     // scl released, stretch wait
  localparam logic [1:0] Q_HIGH  = 2'h2;                     // scl high, sda sampled
  localparam logic [1:0] Q_FALL  = 2'h3;                     // scl low again

  // controller states, one-hot
  typedef enum logic [7:0] {
    IMTF_IDLE  = 8'h01,
    IMTF_START = 8'h02,
    IMTF_TX    = 8'h04,
    IMTF_TACK  = 8'h08,
    IMTF_RX    = 8'h10,
    IMTF_RACK  = 8'h20,
    IMTF_STOP  = 8'h40,
    IMTF_HOLD  = 8'h80
  } imtf_state_t;

  // software control bits
  typedef struct packed {
    logic startSet;     // one-cycle pulse: request start or repeated start
    logic stopSet;      // one-cycle pulse: request stop
    logic flush;        // one-cycle pulse: drop buffered transmit data
    logic nackRequest;  // level: answer received bytes with not-acknowledge
    logic txIrqEn;      // level: transmit_irq_enable
  } imtf_ctrl_t;

  // status bits seen by software
  typedef struct packed {
    logic busy;         // transaction in progress
    logic startPending; // start request not yet carried out
    logic stopPending;  // stop request not yet carried out
    logic ackStatus;    // last transmitted address or data byte was acknowledged
    logic nackFlag;     // not-acknowledge interrupt flag
  } imtf_stat_t;

endpackage : imtf_pkg

// file: testbench/imtf_slave.sv
// imtf_slave: behavioural i2c slave watching the resolved bus lines
// assumes pull-ups on both lines; it never stretches scl
`timescale 1ns/1ps
module imtf_slave (
  input  wire logic       scl,     // resolved scl
  input  wire logic       sda,     // resolved sda
  input  wire logic       ackOn,   // acknowledge received bytes
  input  wire logic [7:0] rdByte,  // byte returned in a read
  output logic            sdaOe,   // high while pulling sda low
  output logic [7:0]      gotByte, // last byte received
  output int              gotCnt,  // bytes received
  output int              starts,  // start conditions seen
  output int              stops,   // stop conditions seen
  output logic            mAck     // master answer level in a read
);
  int         cnt  = 0; // bit slot within the byte
  logic       rdPh = 0; // slave is sending data
  logic       adPh = 0; // next byte is the address
  logic [7:0] sh;       // shift register
  initial begin
    {sdaOe, mAck, gotCnt, starts, stops} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // start and stop: sda moves while scl is high
  always @(negedge sda) if (scl) begin
    {cnt, rdPh, adPh} = {32'd0, 2'b01};
    starts++;
  end
  always @(posedge sda) if (scl) stops++;
  // sample on scl rise, msb first
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    if (cnt == 7 && !rdPh) begin
      gotByte = sh;
      gotCnt++;
    end
    if (cnt == 8) begin
      mAck = sda;
      rdPh = adPh ? sh[0] : rdPh && !sda;
      adPh = 0;
    end
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  // change sda only while scl is low
  always @(negedge scl)
    sdaOe = (cnt == 8) ? !rdPh && ackOn : rdPh && !rdByte[3'(7 - cnt)];
endmodule : imtf_slave

// file: testbench/tb_top.sv
// tb_top: self-checking bench for the i2c master sequencer
// assumes the slave model above and pull-ups on scl and sda
`timescale 1ns/1ps
module tb_top;
  import imtf_pkg::*;
  logic       clk = 0, rst_n = 0, txValid = 0, ackOn = 1;       // bench drives
  logic [7:0] txData = 8'h00, rdByte = 8'h00, rxData, gotByte;  // data bytes
  logic       txIrq, txReady, rxValid, sclOut, sclOe, sdaOut, sdaOe, sOe, mAck;
  imtf_ctrl_t ctrl = '0;                                        // control bits
  imtf_stat_t stat;                                             // status bits
  int         gotCnt, starts, stops, nk = 0, miscompares = 0, samples_checked = 0;
  logic [7:0] exp[$];                                           // expected bytes
  wire        scl = !sclOe;                                     // open drain
  wire        sda = !(sdaOe || sOe);                            // open drain
  initial forever #4 clk = ~clk;
  imtf_master i_imtf_master (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .stat(stat), .txIrq(txIrq),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
  imtf_slave i_imtf_slave (.scl(scl), .sda(sda), .ackOn(ackOn), .rdByte(rdByte), .sdaOe(sOe),
    .gotByte(gotByte), .gotCnt(gotCnt), .starts(starts), .stops(stops), .mAck(mAck));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [7:0] seen, logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  function automatic logic cnd(int k);
    case (k)
      0: return txIrq;
      1: return stat.nackFlag;
      2: return !stat.busy;
      default: return rxValid;
    endcase
  endfunction : cnd
  // bounded wait for a condition
  task automatic waitc(int k);
    int i;
    for (i = 0; i < 4000 && cnd(k) !== 1'b1; i++) cyc();
    if (i == 4000) begin
      miscompares++;
      finish_test();
    end
  endtask : waitc
  task automatic push(logic [7:0] b, bit keep);
    cyc();
    txData = b;
    txValid = 1;
    @(posedge clk);
    for (int i = 0; i < 50 && !txReady; i++) @(posedge clk);
    #1 txValid = 0;
    if (keep) exp.push_back(b);
  endtask : push
  task automatic ctl(imtf_ctrl_t m);
    ctrl = m;
    cyc();
    ctrl = m & 5'h03;
  endtask : ctl
  ////////////////////////////////////////////////////////////////////////////
  // results: slave bytes and received bytes, oldest note first
  always @(gotCnt) chk(gotByte, exp.pop_front());
  always @(posedge clk) if (rxValid === 1'b1) chk(rxData, exp.pop_front());
  always @(posedge stat.nackFlag) nk++;
  task automatic rd(bit fresh);
    int s0 = starts;
    rdByte = 8'($urandom);
    if (fresh) push({7'($urandom), 1'b1}, 1);
    ctl(5'h12);
    exp.push_back(rdByte);
    waitc(3);
    cyc(40);
    chk(8'(mAck), 8'h01);
    chk(8'(starts - s0), 8'h01);
    ctl(5'h0a);
    waitc(2);
    chk(8'(stat & 5'h1d), 8'h00);
  endtask : rd
  // mode 0 stop ending, 1 data nack, 2 restart into a read
  task automatic wr(int n, int mode);
    int s0 = stops;
    int n0 = nk;
    ackOn = 1;
    push({7'($urandom), 1'b0}, 1);
    ctl(5'h11);
    for (int i = 1; i <= n + 1; i++) begin
      waitc(0);
      if (i <= n) push(8'($urandom), 1);
    end
    chk(8'(stat.ackStatus), 8'h01);
    if (mode == 2) begin
      push({7'($urandom), 1'b1}, 1);
      rd(0);
    end else begin
      ackOn = 0;
      if (mode == 1) begin
        waitc(1);
        chk(8'(stat.ackStatus), 8'h00);
        ctl(5'h0c);
      end else
        ctl(5'h08);
      waitc(2);
      chk(8'(stat & 5'h1d), 8'h00);
      chk(8'(stops - s0), 8'h01);
      chk(8'(txIrq), 8'h00);
      chk(8'(nk - n0), mode == 1 ? 8'h01 : 8'h00);
    end
  endtask : wr
  initial begin
    void'($urandom(95800));
    cyc(3);
    rst_n = 1;
    chk(8'({stat, sclOe, sdaOe, txIrq}), 8'h00);
    repeat (4) push(8'($urandom), 0);
    chk(8'(txReady), 8'h00);
    ctl(5'h04);
    chk(8'(txReady), 8'h01);
    wr(3, 0);
    wr(2, 1);
    wr(1, 2);
    rd(1);
    chk(8'({sclOut, sdaOut, sclOe, sdaOe}), 8'h00);
    finish_test();
  end
endmodule : tb_top
